/* File: topc_pkg.sv */
// Package for the timer0 prescaler option control block
`default_nettype none
package topc_pkg;
  // Register map; the option register takes one aligned word
  localparam logic [11:0] OPTION_ADDR   = 12'h000;
  localparam logic [11:0] PULLUP_ADDR   = 12'h004;
  localparam logic [11:0] COUNT_ADDR    = 12'h008;
  localparam logic [7:0]  OPTION_RESET  = 8'hff;
  localparam logic [7:0]  PULLUP_RESET  = 8'h00;
  // Field positions of the option register, pin count and prescaler width
  localparam int BIT_PULLUP_DIS = 7;
  localparam int BIT_INT_EDGE   = 6;
  localparam int BIT_T0_SRC     = 5;
  localparam int BIT_T0_EDGE    = 4;
  localparam int BIT_PRESC_ASSIGN = 3;
  localparam int RATE_LSB       = 0;
  localparam int RATE_W         = 3;
  localparam int PIN_COUNT      = 8;
  localparam int PRESC_W        = 8;
endpackage
`default_nettype wire

/* File: topc_prescaler.sv */
// Shared prescaler with power-of-two tap selection
`default_nettype none
module topc_prescaler
(
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic                           tick,
  input  wire logic [topc_pkg::RATE_W-1:0]    rate,
  input  wire logic                           bypass_first,
  output logic                                out_pulse
);
  logic [topc_pkg::PRESC_W-1:0] cnt_r;
  logic [topc_pkg::PRESC_W-1:0] mask_w;
  logic [topc_pkg::PRESC_W:0]   full_w;

  // Divide count: timer 2^(n+1), watchdog 2^n; four-bit shift so code 111 reaches 1:256
  assign full_w = {{topc_pkg::PRESC_W{1'b0}}, 1'b1} <<
                  ({1'b0, rate} + {3'b000, ~bypass_first});
  assign mask_w = full_w[topc_pkg::PRESC_W-1:0] - 8'h01;
  assign out_pulse = tick && ((cnt_r & mask_w) == mask_w);

  // Free running prescale counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (tick)
      cnt_r <= cnt_r + 8'h01;
  end
endmodule
`default_nettype wire

/* File: topc_top.sv */
// Option control register with timer0 source, prescaler and pull-up gating
`default_nettype none
// Contract
// - Option bit 7 high disables all weak pull-ups, low enables them.
// - A pin pull-up is active only with global enable and its own bit.
// - Bit 6 low: interrupt on rising edge; high: on falling edge.
// - Bit 5 high counts external clock pin; low counts instruction cycles.
// - Bit 4 high counts falling pin edges, low counts rising ones.
// - Bit 3 high gives prescaler to watchdog, low to timer0.
// - Rate field doubles per step: timer 1:2..1:256, watchdog 1:1..1:128.
// - All eight option bits are read/write and reset to one.
module topc_top
(
  input  wire logic                               core_clk,
  input  wire logic                               rst_n,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [11:0]                        paddr,
  input  wire logic [31:0]                        pwdata,
  output logic                                    pready,
  output logic [31:0]                             prdata,
  output logic                                    pslverr,
  input  wire logic                               timer0_ext_clock_pin,
  input  wire logic                               ext_interrupt_pin,
  input  wire logic                               wdt_tick,
  output logic [topc_pkg::PIN_COUNT-1:0]          pullup_active,
  output logic                                    ext_interrupt_pulse,
  output logic                                    timer0_inc,
  output logic                                    wdt_timeout_tick,
  output logic [7:0]                              timer0_count
);
  logic [7:0]                         option_r;
  logic [topc_pkg::PIN_COUNT-1:0]     pin_pullup_enable_r;
  logic [7:0]                         timer0_count_r;
  logic [1:0]                         t0_sync_r;
  logic [1:0]                         int_sync_r;
  logic                               t0_prev_r;
  logic                               int_prev_r;
  logic [31:0]                        prdata_r;

  wire port_pullup_global_disable = option_r[topc_pkg::BIT_PULLUP_DIS];
  wire ext_interrupt_edge_select  = option_r[topc_pkg::BIT_INT_EDGE];
  wire timer0_source_select       = option_r[topc_pkg::BIT_T0_SRC];
  wire timer0_source_edge_select  = option_r[topc_pkg::BIT_T0_EDGE];
  wire prescaler_assign_select    = option_r[topc_pkg::BIT_PRESC_ASSIGN];
  wire [topc_pkg::RATE_W-1:0] prescale_rate_select =
    option_r[topc_pkg::RATE_LSB +: topc_pkg::RATE_W];

  // Bus decode
  wire acc_w    = psel && penable;
  wire wr_w     = acc_w && pwrite;
  wire hit_opt  = paddr == topc_pkg::OPTION_ADDR;
  wire hit_pu   = paddr == topc_pkg::PULLUP_ADDR;
  wire hit_cnt  = paddr == topc_pkg::COUNT_ADDR;
  wire mapped_w = hit_opt || hit_pu || hit_cnt;

  assign pready  = 1'b1;
  assign pslverr = acc_w && !mapped_w;
  assign prdata  = prdata_r;

  // Read mux, registered so the access phase returns stable data
  wire [31:0] rd_w = hit_opt ? {24'h00_0000, option_r} :
                     hit_pu  ? {24'h00_0000, pin_pullup_enable_r} :
                     hit_cnt ? {24'h00_0000, timer0_count_r} : 32'h0000_0000;

  // Option and pull-up registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      option_r            <= topc_pkg::OPTION_RESET;
      pin_pullup_enable_r <= topc_pkg::PULLUP_RESET;
    end
    else
    begin
      if (wr_w && hit_opt)
        option_r <= pwdata[7:0];
      if (wr_w && hit_pu)
        pin_pullup_enable_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_r <= rd_w;
  end

  // Pull-up gating
  assign pullup_active = port_pullup_global_disable ? '0 : pin_pullup_enable_r;

  // Pin synchronisers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      t0_sync_r  <= 2'b00;
      int_sync_r <= 2'b00;
      t0_prev_r  <= 1'b0;
      int_prev_r <= 1'b0;
    end
    else
    begin
      t0_sync_r  <= {t0_sync_r[0], timer0_ext_clock_pin};
      int_sync_r <= {int_sync_r[0], ext_interrupt_pin};
      t0_prev_r  <= t0_sync_r[1];
      int_prev_r <= int_sync_r[1];
    end
  end

  // Edge detection
  wire t0_rise  = t0_sync_r[1] && !t0_prev_r;
  wire t0_fall  = !t0_sync_r[1] && t0_prev_r;
  wire int_rise = int_sync_r[1] && !int_prev_r;
  wire int_fall = !int_sync_r[1] && int_prev_r;

  assign ext_interrupt_pulse = ext_interrupt_edge_select ? int_fall : int_rise;

  wire ext_evt_w = timer0_source_edge_select ? t0_fall : t0_rise;
  wire src_evt_w = timer0_source_select ? ext_evt_w : 1'b1;

  // Prescaler input follows the assignment
  wire presc_tick_w = prescaler_assign_select ? wdt_tick : src_evt_w;
  wire presc_out_w;

  topc_prescaler u_presc
  (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .tick         (presc_tick_w),
    .rate         (prescale_rate_select),
    .bypass_first (prescaler_assign_select),
    .out_pulse    (presc_out_w)
  );

  assign timer0_inc       = prescaler_assign_select ? src_evt_w : presc_out_w;
  assign wdt_timeout_tick = prescaler_assign_select ? presc_out_w : wdt_tick;
  assign timer0_count     = timer0_count_r;

  // Timer0 counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      timer0_count_r <= 8'h00;
    else if (timer0_inc)
      timer0_count_r <= timer0_count_r + 8'h01;
  end

  // Helper: cycles since last timer0 increment for internal source
  logic [8:0] gap_r;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || timer0_inc)
      gap_r <= 9'h000;
    else
      gap_r <= gap_r + 9'h001;
  end

  // Helper: period measured under one setting; a write restarts it, the prescale count is kept
  logic steady_r;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      steady_r <= 1'b0;
    else if (wr_w && hit_opt)
      steady_r <= 1'b0;
    else if (timer0_inc)
      steady_r <= 1'b1;
  end

  // Checks on the option controls
  pullup_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    option_r[7] |-> pullup_active == 8'h00) else $error("pull-up active while disabled");
  pullup_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !option_r[7] |-> pullup_active == pin_pullup_enable_r) else $error("pull-up mismatch");
  int_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ext_interrupt_pulse |-> (option_r[6] ? !int_sync_r[1] : int_sync_r[1]))
    else $error("interrupt on wrong edge");
  int_source_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!option_r[5] && option_r[3]) |-> timer0_inc) else $error("internal count missed");
  ext_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (option_r[5] && option_r[3] && timer0_inc) |->
    (option_r[4] ? t0_prev_r && !t0_sync_r[1] : !t0_prev_r && t0_sync_r[1]))
    else $error("external count on wrong edge");
  wdt_bypass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!option_r[3]) |-> wdt_timeout_tick == wdt_tick) else $error("watchdog divided");
  rate_div_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (timer0_inc && steady_r && !option_r[5] && !option_r[3]) |->
    gap_r == ((9'h002 << option_r[2:0]) - 9'h001))
    else $error("timer0 prescale wrong");
  option_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_w && hit_opt) |=> option_r == $past(pwdata[7:0])) else $error("option write lost");
  option_reset_a: assert property (@(posedge core_clk)
    !rst_n |=> option_r == 8'hff) else $error("option reset wrong");
  undivided_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    option_r[3] |-> timer0_inc == src_evt_w) else $error("timer0 divided under watchdog");

  // Reset, readback, count step, stray write and divider routing checks
  pullup_reset_a: assert property (@(posedge core_clk)
    !rst_n |=> pullup_active == 8'h00) else $error("pull-up active after reset");
  count_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    timer0_inc |=> timer0_count == $past(timer0_count) + 8'h01)
    else $error("timer0 step wrong");
  read_back_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && hit_opt) |=> prdata == {24'h00_0000, $past(option_r)})
    else $error("option readback wrong");
  unmapped_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_w && !mapped_w) |=> option_r == $past(option_r))
    else $error("option changed by stray write");
  timer_divided_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !option_r[3] |-> timer0_inc == presc_out_w)
    else $error("timer0 bypassed prescaler");
  wdt_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (option_r[3] && option_r[2:0] == 3'b000) |-> wdt_timeout_tick == wdt_tick)
    else $error("watchdog pass-through wrong");
endmodule
`default_nettype wire

/* File: topc_pin_model.sv */
// Model of the external timer clock and interrupt pins
`default_nettype none
module topc_pin_model
(
  input  wire logic core_clk,
  input  wire logic tclk_lvl,
  input  wire logic int_lvl,
  output logic      tclk_pin,
  output logic      int_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {tclk_pin, int_pin} = 2'h0;
  // Pins follow the requested levels a cycle later, still otherwise
  always @(posedge core_clk)
  begin
    tclk_pin <= tclk_lvl;
    int_pin  <= int_lvl;
  end
endmodule
`default_nettype wire

/* File: timer0_wdt_prescaler_option_control_bench.sv */
// Self-checking bench for the option control block
`default_nettype none
module timer0_wdt_prescaler_option_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, wdt_tick;
  logic        int_pulse, t0_inc, wdt_out, tclk_lvl, int_lvl, tclk_pin, int_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, e;
  logic [7:0]  pull, cnt8, o;
  int          seed, bad_count, compares, cycles, n, c;
  topc_top uut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .timer0_ext_clock_pin(tclk_pin), .ext_interrupt_pin(int_pin),
    .wdt_tick, .pullup_active(pull), .ext_interrupt_pulse(int_pulse),
    .timer0_inc(t0_inc), .wdt_timeout_tick(wdt_out), .timer0_count(cnt8));
  topc_pin_model pins (.core_clk, .tclk_lvl, .int_lvl, .tclk_pin, .int_pin);
  // Clock
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  // Watchdog oscillator ticks and hang limit
  always @(posedge core_clk)
  begin
    wdt_tick <= ~wdt_tick;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One APB transfer; waits for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Cycles between the second and third pulse
  task automatic gap(input logic wdt, output int len);
    for (int k = 0; k < 3; k++)
    begin
      len = 0;
      do
      begin
        @(posedge core_clk);
        #1 len++;
      end while ((wdt ? wdt_out : t0_inc) !== 1'h1);
    end
  endtask
  // Sets a pin level and counts pulses that follow
  task automatic edges(input logic on_int, input logic lvl, output int cnt);
    cnt = 0;
    @(posedge core_clk);
    if (on_int) int_lvl <= lvl;
    else tclk_lvl <= lvl;
    repeat (8)
    begin
      @(posedge core_clk);
      #1 cnt += ((on_int ? int_pulse : t0_inc) === 1'h1);
    end
  endtask
  function automatic logic [7:0] exp_pull(input logic [7:0] opt, input logic [7:0] en);
    return opt[7] ? 8'h00 : en;
  endfunction
  function automatic logic [31:0] exp_gap(input logic [7:0] opt, input logic wdt);
    return (opt[3] && !wdt) ? 32'h1 : 32'h2 << opt[2:0];
  endfunction
  // Main sequence
  initial
  begin
    seed = 32'h1ab0_1813;
    {rst_n, psel, penable, pwrite, wdt_tick, tclk_lvl, int_lvl} = 7'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {bad_count, compares, cycles} = '0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    apb(1'h0, topc_pkg::OPTION_ADDR, 32'h0);
    chk("option", 32'h0000_00ff, rd);
    chk("pullups", 32'h0, {24'h0, pull});
    apb(1'h0, 12'h00c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test reset done");
    for (n = 0; n < 12; n++)
    begin
      d = $random(seed);
      e = $random(seed);
      if (n < 2) d[7] = n[0];
      apb(1'h1, topc_pkg::OPTION_ADDR, d);
      apb(1'h1, topc_pkg::PULLUP_ADDR, e);
      apb(1'h0, topc_pkg::OPTION_ADDR, 32'h0);
      chk("option", {24'h0, d[7:0]}, rd);
      #1 chk("pullups", {24'h0, exp_pull(d[7:0], e[7:0])}, {24'h0, pull});
    end
    $display("test registers done");
    for (n = 0; n < 24; n++)
    begin
      o = (n < 16) ? {4'h8, n[3], n[2:0]} : {5'h11, n[2:0]};
      apb(1'h1, topc_pkg::OPTION_ADDR, {24'h0, o});
      gap(n >= 16, c);
      chk("spacing", exp_gap(o, n >= 16), c);
    end
    $display("test prescaler done");
    for (n = 0; n < 4; n++)
    begin
      apb(1'h1, topc_pkg::OPTION_ADDR, n[1] ? 32'h80 | n[0] << 6 : 32'ha8 | n[0] << 4);
      apb(1'h0, topc_pkg::COUNT_ADDR, 32'h0);
      o = rd[7:0];
      edges(n[1], 1'h1, c);
      chk("rise pulses", {31'h0, ~n[0]}, c);
      edges(n[1], 1'h0, c);
      chk("fall pulses", {31'h0, n[0]}, c);
      apb(1'h0, topc_pkg::COUNT_ADDR, 32'h0);
      if (!n[1])
      begin
        chk("count read", {24'h0, o + 8'h01}, rd);
        #1 chk("count port", {24'h0, o + 8'h01}, {24'h0, cnt8});
      end
    end
    $display("test edges done");
    give_verdict();
  end
endmodule
`default_nettype wire
